// file: tpp_consts.svh
// Constants of the three-pin port: register indices, field positions,
// reset values and synchroniser depth.
// Assumes inclusion by bare name from the package, tpp_port and the bench.
`ifndef TPP_CONSTS_SVH
`define TPP_CONSTS_SVH

// Register indices; byte address is four times the index
`define TPP_IDX_LEVEL 16'hf21a
`define TPP_IDX_DIR 16'hf21b
`define TPP_IDX_CFG_LO 16'hf21c
`define TPP_IDX_CFG_HI 16'hf21d
`define TPP_IDX_OUT_VAL 16'hf21e

// Field positions (pin bits 4 down to 2)
`define TPP_BIT_IN_ONLY 2
`define TPP_BIT_BIDIR 3
`define TPP_BIT_TEST 4
`define TPP_BIT_LO 2
`define TPP_BIT_HI 4

// Reset values
`define TPP_RST_DIR 8'h10
`define TPP_RST_CFG_LO 8'h10
`define TPP_RST_CFG_HI 8'h00
`define TPP_RST_OUT_VAL 8'h00

// AXI responses
`define TPP_RESP_OKAY 2'h0
`define TPP_RESP_SLVERR 2'h2

// Synchroniser depth
`define TPP_SYNC_STAGES 2

`endif

// file: tpp_pkg.sv
// Types shared by the three-pin port modules.
// Assumes tpp_consts.svh is on the include path.
package tpp_pkg;
  `include "tpp_consts.svh"

  // Output driver selection for a pin in output mode
  typedef enum logic [1:0] {
    TPP_DRV_HIZ  = 2'h0,
    TPP_DRV_PODR = 2'h1,
    TPP_DRV_NODR = 2'h2,
    TPP_DRV_CMOS = 2'h3
  } tpp_drv_t;

  // Input conditioning selection for a pin in input mode
  typedef enum logic [1:0] {
    TPP_IN_HIZ  = 2'h0,
    TPP_IN_PD   = 2'h1,
    TPP_IN_PU   = 2'h2,
    TPP_IN_HIZ2 = 2'h3
  } tpp_in_t;

  // Decoded register selection
  typedef enum logic [2:0] {
    TPP_SEL_LEVEL = 3'h0,
    TPP_SEL_DIR   = 3'h1,
    TPP_SEL_CFG   = 3'h2,
    TPP_SEL_CFGHI = 3'h3,
    TPP_SEL_OUT   = 3'h4,
    TPP_SEL_NONE  = 3'h7
  } tpp_sel_t;
endpackage

// file: tpp_sync.sv
// Two-stage synchroniser for a group of pin levels.
// Assumes asynchronous inputs; output is a clean level on core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module tpp_sync #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: tpp_pin_drive.sv
// Pad control for one port pin: driver type, pulls and output enable.
// Assumes the pad cell resolves out, enable and pull requests; outputs registered.
`timescale 1ns/10ps
`default_nettype none
module tpp_pin_drive
  import tpp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic dir_in_i,
  input wire logic [1:0] cfg_i,
  input wire logic out_val_i,
  input wire logic force_hiz_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic pull_up_o,
  output logic pull_down_o
);
  logic pin_d;
  logic oe_d;
  logic pu_d;
  logic pd_d;

  always_comb begin
    pin_d = 1'b0;
    oe_d = 1'b0;
    pu_d = 1'b0;
    pd_d = 1'b0;
    if (force_hiz_i) begin
      pin_d = 1'b0;
    end else if (dir_in_i) begin
      pu_d = (tpp_in_t'(cfg_i) == TPP_IN_PU);
      pd_d = (tpp_in_t'(cfg_i) == TPP_IN_PD);
    end else begin
      unique case (tpp_drv_t'(cfg_i))
        TPP_DRV_HIZ: begin
          oe_d = 1'b0;
        end
        TPP_DRV_PODR: begin
          pin_d = 1'b1;
          oe_d = out_val_i;
        end
        TPP_DRV_NODR: begin
          pin_d = 1'b0;
          oe_d = ~out_val_i;
        end
        TPP_DRV_CMOS: begin
          pin_d = out_val_i;
          oe_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_down_o <= 1'b0;
    end else begin
      pin_o <= pin_d;
      pin_oe_o <= oe_d;
      pull_up_o <= pu_d;
      pull_down_o <= pd_d;
    end
  end
endmodule
`default_nettype wire

// file: tpp_port.sv
// Three-pin general-purpose input port with AXI4-Lite register access.
// Assumes asynchronous pin inputs and a pad cell that applies pulls and enables.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tpp_consts.svh"
module tpp_port
  import tpp_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter bit XTAL_EN = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic input_only_pin_i,
  input wire logic bidir_pin_i,
  output logic bidir_pin_o,
  output logic bidir_pin_oe_o,
  input wire logic test_capable_pin_i,
  output logic test_capable_pin_o,
  output logic test_capable_pin_oe_o,
  output logic [2:0] pull_up_o,
  output logic [2:0] pull_down_o,
  output logic crystal_mode_o
);
  localparam int NPIN = 3;
  // Reset images as full bytes, sliced to the implemented bits where used
  localparam logic [7:0] RST_DIR = `TPP_RST_DIR;
  localparam logic [7:0] RST_CFG_LO = `TPP_RST_CFG_LO;
  localparam logic [7:0] RST_CFG_HI = `TPP_RST_CFG_HI;
  localparam logic [7:0] RST_OUT_VAL = `TPP_RST_OUT_VAL;

  logic [NPIN-1:0] pin_level;
  logic [`TPP_BIT_HI:`TPP_BIT_LO] dir_q;
  logic [`TPP_BIT_HI:`TPP_BIT_LO] cfg_lo_q;
  logic [`TPP_BIT_HI:`TPP_BIT_LO] cfg_hi_q;
  logic [`TPP_BIT_HI:`TPP_BIT_LO] out_val_q;
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  tpp_sel_t wr_sel;
  tpp_sel_t rd_sel;
  logic rd_fire;
  logic [31:0] rd_data;
  logic [NPIN-1:0] dir_in;
  logic [NPIN-1:0] force_hiz;
  logic [NPIN-1:0] drv_o;
  logic [NPIN-1:0] drv_oe;
  logic [NPIN-1:0] pin_async;

  function automatic tpp_sel_t tpp_decode(input logic [ADDR_W-1:0] addr);
    tpp_sel_t sel;
    sel = TPP_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[ADDR_W-1:2])
        (ADDR_W-2)'(`TPP_IDX_LEVEL): sel = TPP_SEL_LEVEL;
        (ADDR_W-2)'(`TPP_IDX_DIR): sel = TPP_SEL_DIR;
        (ADDR_W-2)'(`TPP_IDX_CFG_LO): sel = TPP_SEL_CFG;
        (ADDR_W-2)'(`TPP_IDX_CFG_HI): sel = TPP_SEL_CFGHI;
        (ADDR_W-2)'(`TPP_IDX_OUT_VAL): sel = TPP_SEL_OUT;
        default: sel = TPP_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Pin levels enter through two flip-flops
  assign pin_async = {test_capable_pin_i, bidir_pin_i, input_only_pin_i};

  tpp_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(pin_async),
    .sync_o(pin_level)
  );

  // Write address and data are taken independently
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w_have_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_sel = tpp_decode(awaddr_q);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_awready <= !(aw_have_q || (s_axi_awvalid && s_axi_awready)) || wr_fire;
      s_axi_wready <= !(w_have_q || (s_axi_wvalid && s_axi_wready)) || wr_fire;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TPP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == TPP_SEL_NONE) ? `TPP_RESP_SLVERR : `TPP_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Direction register; level register writes fall through unused
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= RST_DIR[`TPP_BIT_HI:`TPP_BIT_LO];
    end else if (wr_fire && wr_sel == TPP_SEL_DIR && wstrb_q[0]) begin
      dir_q[`TPP_BIT_HI:`TPP_BIT_BIDIR] <= wdata_q[`TPP_BIT_HI:`TPP_BIT_BIDIR];
    end
  end

  // Config pair, byte-wide or as one word at the low address
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_lo_q <= RST_CFG_LO[`TPP_BIT_HI:`TPP_BIT_LO];
    end else if (wr_fire && wr_sel == TPP_SEL_CFG && wstrb_q[0]) begin
      cfg_lo_q <= wdata_q[`TPP_BIT_HI:`TPP_BIT_LO];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_hi_q <= RST_CFG_HI[`TPP_BIT_HI:`TPP_BIT_LO];
    end else if (wr_fire && wr_sel == TPP_SEL_CFG && wstrb_q[1]) begin
      cfg_hi_q <= wdata_q[8+`TPP_BIT_HI:8+`TPP_BIT_LO];
    end else if (wr_fire && wr_sel == TPP_SEL_CFGHI && wstrb_q[0]) begin
      cfg_hi_q <= wdata_q[`TPP_BIT_HI:`TPP_BIT_LO];
    end
  end

  // Output levels for pins in output mode
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_val_q <= RST_OUT_VAL[`TPP_BIT_HI:`TPP_BIT_LO];
    end else if (wr_fire && wr_sel == TPP_SEL_OUT && wstrb_q[0]) begin
      out_val_q <= wdata_q[`TPP_BIT_HI:`TPP_BIT_LO];
    end
  end

  // Read path
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_sel = tpp_decode(s_axi_araddr);

  always_comb begin
    rd_data = 32'h0;
    unique case (rd_sel)
      TPP_SEL_LEVEL: rd_data[`TPP_BIT_HI:`TPP_BIT_LO] = pin_level;
      TPP_SEL_DIR: rd_data[`TPP_BIT_HI:`TPP_BIT_LO] = dir_q;
      TPP_SEL_CFG: begin
        rd_data[`TPP_BIT_HI:`TPP_BIT_LO] = cfg_lo_q;
        rd_data[8+`TPP_BIT_HI:8+`TPP_BIT_LO] = cfg_hi_q;
      end
      TPP_SEL_CFGHI: rd_data[`TPP_BIT_HI:`TPP_BIT_LO] = cfg_hi_q;
      TPP_SEL_OUT: rd_data[`TPP_BIT_HI:`TPP_BIT_LO] = out_val_q;
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TPP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= (rd_sel == TPP_SEL_NONE) ? `TPP_RESP_SLVERR : `TPP_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin drivers; input-only pin never leaves input mode
  assign dir_in = {dir_q[`TPP_BIT_TEST], dir_q[`TPP_BIT_BIDIR], 1'b1};
  assign force_hiz = {1'b0, XTAL_EN, XTAL_EN};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      tpp_pin_drive u_drive (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .dir_in_i(dir_in[g]),
        .cfg_i({cfg_hi_q[`TPP_BIT_LO+g], cfg_lo_q[`TPP_BIT_LO+g]}),
        .out_val_i(out_val_q[`TPP_BIT_LO+g]),
        .force_hiz_i(force_hiz[g]),
        .pin_o(drv_o[g]),
        .pin_oe_o(drv_oe[g]),
        .pull_up_o(pull_up_o[g]),
        .pull_down_o(pull_down_o[g])
      );
    end
  endgenerate

  assign bidir_pin_o = drv_o[1];
  assign bidir_pin_oe_o = drv_oe[1];
  assign test_capable_pin_o = drv_o[2];
  assign test_capable_pin_oe_o = drv_oe[2];

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crystal_mode_o <= 1'b0;
    end else begin
      crystal_mode_o <= XTAL_EN;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_level_value: assert property (
    (rd_fire && rd_sel == TPP_SEL_LEVEL)
      |=> s_axi_rdata[4:2] == $past(pin_level) && s_axi_rvalid)
    else $error("level read does not show pin levels");

  chk_level_ro: assert property (
    (wr_fire && wr_sel == TPP_SEL_LEVEL)
      |=> $stable(dir_q) && $stable(cfg_lo_q) && $stable(cfg_hi_q))
    else $error("write to level register changed state");

  chk_dir_reset: assert property (
    $rose(rst_n_i) |-> dir_q[4] && !dir_q[3])
    else $error("direction bits not at reset value");

  chk_cfg_reset: assert property (
    $rose(rst_n_i) |-> cfg_lo_q == 3'h4 && cfg_hi_q == 3'h0)
    else $error("config pair not at reset value");

  chk_bidir_cmos: assert property (
    (!XTAL_EN && !dir_q[3] && cfg_hi_q[3] && cfg_lo_q[3])
      |=> bidir_pin_oe_o && bidir_pin_o == $past(out_val_q[3]))
    else $error("bidir CMOS drive wrong");

  chk_bidir_ndrain: assert property (
    (!XTAL_EN && !dir_q[3] && cfg_hi_q[3] && !cfg_lo_q[3])
      |=> !bidir_pin_o && bidir_pin_oe_o == !$past(out_val_q[3]))
    else $error("bidir N-drain drive wrong");

  chk_bidir_pdrain: assert property (
    (!XTAL_EN && !dir_q[3] && !cfg_hi_q[3] && cfg_lo_q[3])
      |=> bidir_pin_o && bidir_pin_oe_o == $past(out_val_q[3]))
    else $error("bidir P-drain drive wrong");

  chk_bidir_hiz_out: assert property (
    (!XTAL_EN && !dir_q[3] && !cfg_hi_q[3] && !cfg_lo_q[3])
      |=> !bidir_pin_oe_o && !pull_up_o[1] && !pull_down_o[1])
    else $error("bidir high-impedance output drives");

  chk_test_pin_input: assert property (
    dir_q[4] |=> !test_capable_pin_oe_o)
    else $error("test pin driven while in input mode");

  chk_bidir_pullup: assert property (
    (!XTAL_EN && dir_q[3] && cfg_hi_q[3] && !cfg_lo_q[3])
      |=> pull_up_o[1] && !pull_down_o[1] && !bidir_pin_oe_o)
    else $error("bidir input pull-up wrong");

  chk_input_only_pd: assert property (
    (!XTAL_EN && !cfg_hi_q[2] && cfg_lo_q[2])
      |=> pull_down_o[0] && !pull_up_o[0])
    else $error("input-only pull-down wrong");

  chk_xtal_hiz: assert property (
    XTAL_EN |=> !bidir_pin_oe_o && pull_up_o[1:0] == 2'h0 && pull_down_o[1:0] == 2'h0)
    else $error("crystal pins not high impedance");

  chk_unused_zero: assert property (
    (rd_fire && rd_sel == TPP_SEL_DIR)
      |=> s_axi_rdata[31:5] == 27'h0 && s_axi_rdata[1:0] == 2'h0)
    else $error("unimplemented bits read nonzero");

  chk_word_write: assert property (
    (wr_fire && wr_sel == TPP_SEL_CFG && wstrb_q[1])
      |=> cfg_hi_q == $past(wdata_q[12:10]))
    else $error("word write missed high config");

  chk_bresp_follow: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");

  cov_word_write: cover property (wr_fire && wr_sel == TPP_SEL_CFG && wstrb_q == 4'h3);
  cov_level_read: cover property (rd_fire && rd_sel == TPP_SEL_LEVEL);
  cov_bidir_out: cover property (bidir_pin_oe_o && bidir_pin_o);
  cov_unmapped: cover property (rd_fire && rd_sel == TPP_SEL_NONE);
endmodule
`default_nettype wire

// file: tpp_board_model.sv
// Board model for the three-pin port: pad wires with drivers and pulls.
// Assumes bench-driven board levels; an undriven, unpulled pin toggles each cycle.
`timescale 1ns/10ps
`default_nettype none
module tpp_board_model (
  input wire logic core_clk_i,
  input wire logic [2:0] ext_lvl_i,
  input wire logic [2:0] ext_en_i,
  input wire logic [2:0] drv_i,
  input wire logic [2:0] drv_oe_i,
  input wire logic [2:0] pull_up_i,
  input wire logic [2:0] pull_down_i,
  output logic [2:0] pin_lvl_o
);
  logic [2:0] float_q = 3'h5;

  always_ff @(posedge core_clk_i) begin
    float_q <= ~float_q;
  end

  // Port driver first, then board driver, then pull, else no stable level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (drv_oe_i[i]) begin
        pin_lvl_o[i] = drv_i[i];
      end else if (ext_en_i[i]) begin
        pin_lvl_o[i] = ext_lvl_i[i];
      end else if (pull_up_i[i]) begin
        pin_lvl_o[i] = 1'b1;
      end else if (pull_down_i[i]) begin
        pin_lvl_o[i] = 1'b0;
      end else begin
        pin_lvl_o[i] = float_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: three_pin_input_port_tb_top.sv
// Self-checking bench for the three-pin port: registers and pad control.
// Assumes tpp_pkg, tpp_port and tpp_board_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "tpp_consts.svh"
module three_pin_input_port_tb_top;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [19:0] s_axi_awaddr = '0;
  logic [19:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic bidir_pin_o, bidir_pin_oe_o, test_capable_pin_o, test_capable_pin_oe_o, crystal_mode_o;
  logic [2:0] pull_up_o, pull_down_o, x_pu, x_pd, pin_lvl;
  logic [2:0] ext_lvl = '0;
  logic [2:0] ext_en = '0;
  logic x_oe, x_xm;
  int error_cnt = 0;
  int checked = 0;
  logic [31:0] seed = 32'h73caf6f2;

  always #2.5 core_clk_i = ~core_clk_i;

  tpp_port dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .input_only_pin_i(pin_lvl[0]), .bidir_pin_i(pin_lvl[1]),
    .bidir_pin_o(bidir_pin_o), .bidir_pin_oe_o(bidir_pin_oe_o),
    .test_capable_pin_i(pin_lvl[2]), .test_capable_pin_o(test_capable_pin_o),
    .test_capable_pin_oe_o(test_capable_pin_oe_o), .pull_up_o(pull_up_o),
    .pull_down_o(pull_down_o), .crystal_mode_o(crystal_mode_o));

  // Same bus traffic, crystal option on; only its pad outputs are watched
  tpp_port #(.XTAL_EN(1'b1)) xtal_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .input_only_pin_i(pin_lvl[0]), .bidir_pin_i(pin_lvl[1]), .bidir_pin_o(),
    .bidir_pin_oe_o(x_oe), .test_capable_pin_i(pin_lvl[2]), .test_capable_pin_o(),
    .test_capable_pin_oe_o(), .pull_up_o(x_pu), .pull_down_o(x_pd), .crystal_mode_o(x_xm));

  tpp_board_model board_u (
    .core_clk_i(core_clk_i), .ext_lvl_i(ext_lvl), .ext_en_i(ext_en),
    .drv_i({test_capable_pin_o, bidir_pin_o, 1'b0}),
    .drv_oe_i({test_capable_pin_oe_o, bidir_pin_oe_o, 1'b0}),
    .pull_up_i(pull_up_o), .pull_down_i(pull_down_o), .pin_lvl_o(pin_lvl));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [19:0] ba(input logic [15:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Input mode pulls as {up, down}
  function automatic logic [1:0] pl(input logic [1:0] c);
    return (c == 2'h2) ? 2'b10 : ((c == 2'h1) ? 2'b01 : 2'b00);
  endfunction

  // Output mode as {driven value, enable}
  function automatic logic [1:0] dv(input logic [1:0] c, input logic v);
    case (c)
      2'h1: return {v, v};
      2'h2: return {1'b0, ~v};
      2'h3: return {v, 1'b1};
      default: return 2'b00;
    endcase
  endfunction

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: pads %b expected %b", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (s_axi_bvalid !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: write response timeout", $time);
      complete_run();
    end
    chk_word({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [19:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (s_axi_rvalid !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: read data timeout", $time);
      complete_run();
    end
    chk_word(s_axi_rdata, d);
    chk_word({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 1'b0;
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] w;
    logic [1:0] p0, p1, p2, d;
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    chk_pins({pull_up_o, pull_down_o, test_capable_pin_oe_o, crystal_mode_o}, 8'h10);
    chk_pins({x_pu, x_pd, x_oe, x_xm}, 8'h11);
    axi_rd(ba(`TPP_IDX_DIR), 32'h10, `TPP_RESP_OKAY);
    axi_rd(ba(`TPP_IDX_CFG_LO), 32'h10, `TPP_RESP_OKAY);
    axi_rd(ba(`TPP_IDX_CFG_HI), 32'h0, `TPP_RESP_OKAY);
    axi_rd(ba(16'hf219), 32'h0, `TPP_RESP_SLVERR);
    axi_rd(ba(`TPP_IDX_DIR) + 20'h1, 32'h0, `TPP_RESP_SLVERR);
    axi_wr(ba(16'hf230), 32'hffffffff, 4'hf, `TPP_RESP_SLVERR);
    axi_rd(ba(`TPP_IDX_DIR), 32'h10, `TPP_RESP_OKAY);
    // Direction bit 4 is always written as one
    axi_wr(ba(`TPP_IDX_DIR), 32'hffffffff, 4'hf, `TPP_RESP_OKAY);
    axi_rd(ba(`TPP_IDX_DIR), 32'h18, `TPP_RESP_OKAY);
    axi_wr(ba(`TPP_IDX_CFG_LO), 32'hffffffff, 4'hf, `TPP_RESP_OKAY);
    axi_rd(ba(`TPP_IDX_CFG_LO), 32'h1c1c, `TPP_RESP_OKAY);
    axi_wr(ba(`TPP_IDX_CFG_LO), 32'h0, 4'h2, `TPP_RESP_OKAY);
    axi_rd(ba(`TPP_IDX_CFG_LO), 32'h1c, `TPP_RESP_OKAY);
    axi_rd(ba(`TPP_IDX_CFG_HI), 32'h0, `TPP_RESP_OKAY);
    ext_en <= 3'h7;
    for (int i = 0; i < 8; i++) begin
      r = xs();
      ext_lvl <= r[2:0];
      repeat (4) @(posedge core_clk_i);
      if (i == 4) axi_wr(ba(`TPP_IDX_LEVEL), 32'hffffffff, 4'hf, `TPP_RESP_OKAY);
      axi_rd(ba(`TPP_IDX_LEVEL), {27'h0, r[2:0], 2'h0}, `TPP_RESP_OKAY);
    end
    ext_en <= 3'h0;
    for (int i = 0; i < 32; i++) begin
      r = xs();
      if (i < 16) r[7:0] = {i[3], i[2], i[1:0], i[1:0], i[1:0]};
      w = {19'h0, r[5], r[3], r[1], 5'h0, r[4], r[2], r[0], 2'h0};
      axi_wr(ba(`TPP_IDX_DIR), {27'h0, 1'b1, r[6], 3'h0}, 4'h1, `TPP_RESP_OKAY);
      axi_wr(ba(`TPP_IDX_CFG_LO), w, 4'h3, `TPP_RESP_OKAY);
      axi_wr(ba(`TPP_IDX_OUT_VAL), {28'h0, r[7], 3'h0}, 4'h1, `TPP_RESP_OKAY);
      repeat (2) @(posedge core_clk_i);
      p0 = pl(r[1:0]);
      p1 = r[6] ? pl(r[3:2]) : 2'b00;
      p2 = pl(r[5:4]);
      d = r[6] ? 2'b00 : dv(r[3:2], r[7]);
      chk_pins({pull_up_o, pull_down_o, bidir_pin_oe_o, test_capable_pin_oe_o},
               {p2[1], p1[1], p0[1], p2[0], p1[0], p0[0], d[0], 1'b0});
      chk_pins({5'h0, test_capable_pin_o, bidir_pin_o & bidir_pin_oe_o, x_oe},
               {6'h0, d[1], 1'b0});
      chk_pins({x_pu, x_pd, x_oe, x_xm}, {p2[1], 2'b00, p2[0], 2'b00, 2'b01});
      axi_rd(ba(`TPP_IDX_CFG_LO), w, `TPP_RESP_OKAY);
    end
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    axi_rd(ba(`TPP_IDX_DIR), 32'h10, `TPP_RESP_OKAY);
    axi_rd(ba(`TPP_IDX_CFG_LO), 32'h10, `TPP_RESP_OKAY);
    complete_run();
  end
endmodule
`default_nettype wire
